// ===== rtl/amdm_defs.vh
`ifndef AMDM_DEFS_VH
`define AMDM_DEFS_VH

// register byte addresses
`define AMDM_A_CMD 8'h00
`define AMDM_A_HDR 8'h04
`define AMDM_A_ID 8'h08
`define AMDM_A_LOCK 8'h0C
`define AMDM_A_LIM 8'h10
`define AMDM_A_FREE 8'h14
`define AMDM_A_ERR 8'h18
`define AMDM_A_STAT 8'h1C
`define AMDM_A_IST 8'h20
`define AMDM_A_IMASK 8'h24
`define AMDM_A_MODNUM 8'h28
`define AMDM_A_AXCTL 8'h2C
`define AMDM_A_SETPOS 8'h30
`define AMDM_A_SETCMD 8'h34
`define AMDM_A_RBSEL 8'h38
`define AMDM_A_RBHDR 8'h3C
`define AMDM_A_RBLOCK 8'h40
`define AMDM_A_RBLIM 8'h44
`define AMDM_A_RBFREE 8'h48

// command opcodes in CMD[1:0], delete axis in CMD[3:2]
`define AMDM_OP_ENTER 2'h1
`define AMDM_OP_DELETE 2'h2
`define AMDM_F_DELAX 2

// header word: [7:0] set number, [15:8] module number, [17:16] axis
`define AMDM_F_MODNUM 8
`define AMDM_F_AXIS 16
// locked word fields
`define AMDM_F_MEAS 1
`define AMDM_F_RES 4
`define AMDM_F_ENC 24
`define AMDM_MEAS_MAX 2'h2
// limits word: [15:0] start, [31:16] end

// module identity, value is arbitrary
`define AMDM_MODULE_ID 32'h5A3C0F96
`define AMDM_MODNUM_RST 8'h01

// error numbers, zero means the data is correct
`define AMDM_E_NONE 8'h00
`define AMDM_E_MODULE 8'h01
`define AMDM_E_AXIS 8'h02
`define AMDM_E_STATE 8'h03
`define AMDM_E_EXISTS 8'h04
`define AMDM_E_DSN 8'h05
`define AMDM_E_LOCKED 8'h06
`define AMDM_E_RANGE 8'h07
`define AMDM_E_CONTRA 8'h08

// interrupt status bits
`define AMDM_I_OK 0
`define AMDM_I_ERR 1
`define AMDM_I_DEL 2
`define AMDM_I_REFUSE 3
`define AMDM_I_PURGE 4

// per-axis control byte mask: drive dis, round, follow, act cmp, round cmp, track, sim
`define AMDM_CTL_MASK 8'h7F
`define AMDM_SETS 8

`endif

// ===== rtl/amdm_check.v
`timescale 1ns/10ps
`include "amdm_defs.vh"

module amdm_check (
  // staged set
  input wire [31:0] hdr,
  input wire [31:0] id,
  input wire [31:0] lock,
  input wire [31:0] lim,
  // module and axis state
  input wire [7:0] modnum,
  input wire [2:0] axis_done,
  input wire [2:0] md_valid,
  input wire [23:0] md_dsn,
  input wire [95:0] md_lock,
  input wire [95:0] md_lim,
  // verdict
  output reg [7:0] err
);
  reg [1:0] ax;
  reg [1:0] ai;
  reg [7:0] dsn;
  reg clash;
  integer j;

  always @* begin
    ax = hdr[`AMDM_F_AXIS +: 2];
    ai = ax - 2'h1;
    dsn = hdr[7:0];
    clash = 1'b0;
    for (j = 0; j < 3; j = j + 1) begin
      if (md_valid[j] && (j != ai) && (md_dsn[j*8 +: 8] == dsn)) begin
        clash = 1'b1;
      end
    end
    err = `AMDM_E_NONE;
    if ((id != `AMDM_MODULE_ID) || (hdr[`AMDM_F_MODNUM +: 8] != modnum)) begin
      err = `AMDM_E_MODULE;
    end else if (ax == 2'h0) begin
      err = `AMDM_E_AXIS;
    end else if (!axis_done[ai]) begin
      err = `AMDM_E_STATE;
    end else if (md_valid[ai] && (md_dsn[ai*8 +: 8] != dsn)) begin
      err = `AMDM_E_EXISTS;
    end else if (clash) begin
      err = `AMDM_E_DSN;
    end else if (md_valid[ai] &&
                 ((lock != md_lock[ai*32 +: 32]) || (lim != md_lim[ai*32 +: 32]))) begin
      err = `AMDM_E_LOCKED;
    end else if ((dsn == 8'h00) || (lock[`AMDM_F_MEAS +: 2] > `AMDM_MEAS_MAX) ||
                 (lock[`AMDM_F_RES +: 4] == 4'h0)) begin
      err = `AMDM_E_RANGE;
    end else if ((lim[15:0] >= lim[31:16]) || (lock[`AMDM_F_ENC +: 2] == ax)) begin
      err = `AMDM_E_CONTRA;
    end
  end
endmodule

// ===== rtl/amdm_recheck.v
`timescale 1ns/10ps
`include "amdm_defs.vh"

module amdm_recheck (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // new range of the axis just entered
  input wire start,
  input wire [1:0] axis,
  input wire [15:0] lo,
  input wire [15:0] hi,
  // set table entry at idx
  input wire ent_valid,
  input wire [1:0] ent_axis,
  input wire [15:0] ent_lo,
  input wire [15:0] ent_hi,
  // walk
  output wire [2:0] idx,
  output wire kill,
  output wire done
);
  reg run_q;
  reg [2:0] idx_q;

  assign idx = idx_q;
  // one slot per cycle; a set of the entered axis with any edge outside the new range goes
  assign kill = run_q && ent_valid && (ent_axis == axis) &&
                ((ent_lo < lo) || (ent_hi > hi));
  assign done = run_q && (idx_q == 3'h7);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      idx_q <= 3'h0;
    end else if (start) begin
      run_q <= 1'b1;
      idx_q <= 3'h0;
    end else if (run_q) begin
      run_q <= !done;
      idx_q <= idx_q + 3'h1;
    end
  end
endmodule

// ===== rtl/amdm_top.v
`timescale 1ns/10ps
`include "amdm_defs.vh"

module amdm_top (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // controller register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  // programmer register port
  input wire [7:0] pgm_addr,
  input wire [31:0] pgm_wdata,
  input wire pgm_wr,
  input wire pgm_rd,
  output reg [31:0] pgm_rdata_q,
  // axis state
  input wire [2:0] axis_done,
  output reg [2:0] md_valid_q,
  output reg [2:0] axis_clear_q,
  output reg [23:0] axis_ctl_q,
  // interrupt
  output reg irq_q
);
  localparam S_IDLE = 3'b001;
  localparam S_CHECK = 3'b010;
  localparam S_RECHK = 3'b100;

  reg [2:0] state_q;
  reg [31:0] hdr_q;
  reg [31:0] id_q;
  reg [31:0] lock_q;
  reg [31:0] lim_q;
  reg [31:0] free_q;
  reg [7:0] modnum_q;
  reg [23:0] md_dsn_q;
  reg [95:0] md_lock_q;
  reg [95:0] md_lim_q;
  reg [95:0] md_free_q;
  reg [7:0] err_q;
  reg [4:0] ist_q;
  reg [4:0] imask_q;
  reg [1:0] rb_sel_q;
  reg [31:0] setpos_q;
  reg [7:0] set_valid_q;
  reg [15:0] set_axis_q;
  reg [127:0] set_lo_q;
  reg [127:0] set_hi_q;
  reg del_cpl;
  reg [4:0] ev;
  integer j;

  wire [7:0] chk_err;
  wire [2:0] rc_idx;
  wire rc_kill;
  wire rc_done;

  // both ports share one register file; a write on both in one cycle
  // keeps the controller's and drops the programmer's
  wire wr = reg_wr | pgm_wr;
  wire [7:0] waddr = reg_wr ? reg_addr : pgm_addr;
  wire [31:0] wdata = reg_wr ? reg_wdata : pgm_wdata;
  wire busy = (state_q != S_IDLE);
  wire cmd_wr = wr && (waddr == `AMDM_A_CMD);
  wire cmd_enter = cmd_wr && (wdata[1:0] == `AMDM_OP_ENTER);
  wire cmd_del = cmd_wr && (wdata[1:0] == `AMDM_OP_DELETE);
  wire [1:0] del_ax = wdata[`AMDM_F_DELAX +: 2];
  wire stage_wr = wr && !busy;
  // set table command word: slot, owning axis, valid; the range comes from SETPOS
  wire [2:0] slot = wdata[2:0];
  wire [1:0] slot_ax = wdata[4:3];
  wire rc_start = (state_q == S_CHECK) && (chk_err == `AMDM_E_NONE);
  wire rd_clr = (reg_rd && (reg_addr == `AMDM_A_IST)) ||
                (pgm_rd && (pgm_addr == `AMDM_A_IST));

  function [1:0] ax_i;
    input [1:0] ax;
    begin
      ax_i = ax - 2'h1;
    end
  endfunction

  // read decode, shared by both ports
  function [31:0] rd_mux;
    input [7:0] a;
    reg [1:0] ri;
    begin
      ri = ax_i(rb_sel_q);
      rd_mux = 32'h00000000;
      case (a)
        `AMDM_A_HDR: rd_mux = hdr_q;
        `AMDM_A_ID: rd_mux = id_q;
        `AMDM_A_LOCK: rd_mux = lock_q;
        `AMDM_A_LIM: rd_mux = lim_q;
        `AMDM_A_FREE: rd_mux = free_q;
        `AMDM_A_ERR: rd_mux = {24'h000000, err_q};
        `AMDM_A_STAT: rd_mux = {26'h0000000, busy, state_q[2], md_valid_q, 1'b0};
        `AMDM_A_IST: rd_mux = {27'h0000000, ist_q};
        `AMDM_A_IMASK: rd_mux = {27'h0000000, imask_q};
        `AMDM_A_MODNUM: rd_mux = {24'h000000, modnum_q};
        `AMDM_A_AXCTL: rd_mux = {8'h00, axis_ctl_q};
        `AMDM_A_SETPOS: rd_mux = setpos_q;
        `AMDM_A_SETCMD: rd_mux = {24'h000000, set_valid_q};
        `AMDM_A_RBSEL: rd_mux = {30'h00000000, rb_sel_q};
        // stored set readback runs regardless of axis state or busy
        `AMDM_A_RBHDR: begin
          if (rb_sel_q != 2'h0) begin
            rd_mux = {14'h0000, rb_sel_q, modnum_q, md_dsn_q[ri*8 +: 8]};
          end
        end
        `AMDM_A_RBLOCK: begin
          if (rb_sel_q != 2'h0) begin
            rd_mux = md_lock_q[ri*32 +: 32];
          end
        end
        `AMDM_A_RBLIM: begin
          if (rb_sel_q != 2'h0) begin
            rd_mux = md_lim_q[ri*32 +: 32];
          end
        end
        `AMDM_A_RBFREE: begin
          if (rb_sel_q != 2'h0) begin
            rd_mux = md_free_q[ri*32 +: 32];
          end
        end
        default: rd_mux = 32'h00000000;
      endcase
    end
  endfunction

  // an axis still feeding another one's encoder cannot be deleted
  always @* begin
    del_cpl = 1'b0;
    for (j = 0; j < 3; j = j + 1) begin
      if (md_valid_q[j] && (md_lock_q[j*32 + `AMDM_F_ENC +: 2] == del_ax)) begin
        del_cpl = 1'b1;
      end
    end
  end

  // table index of the axis named by a delete and of the staged set
  wire [1:0] del_ai = ax_i(del_ax);
  wire [1:0] ent_ai = ax_i(hdr_q[`AMDM_F_AXIS +: 2]);
  wire del_ok = (del_ax != 2'h0) && !busy && axis_done[del_ai] && !del_cpl;

  always @* begin
    ev = 5'h00;
    ev[`AMDM_I_OK] = (state_q == S_RECHK) && rc_done;
    ev[`AMDM_I_ERR] = (state_q == S_CHECK) && (chk_err != `AMDM_E_NONE);
    ev[`AMDM_I_DEL] = cmd_del && del_ok;
    // refusals: a delete that fails its guards, an enter while busy
    ev[`AMDM_I_REFUSE] = (cmd_del && !del_ok) || (cmd_enter && busy);
    ev[`AMDM_I_PURGE] = rc_kill;
  end

  // next status: an event beats a clearing read in the same cycle
  wire [4:0] ist_d = (rd_clr ? 5'h00 : ist_q) | ev;
  // irq sees a mask write in the same cycle as the status it gates
  wire [4:0] imask_d = (wr && (waddr == `AMDM_A_IMASK)) ? wdata[4:0] : imask_q;

  amdm_check u_check (
    .hdr(hdr_q),
    .id(id_q),
    .lock(lock_q),
    .lim(lim_q),
    .modnum(modnum_q),
    .axis_done(axis_done),
    .md_valid(md_valid_q),
    .md_dsn(md_dsn_q),
    .md_lock(md_lock_q),
    .md_lim(md_lim_q),
    .err(chk_err)
  );

  amdm_recheck u_recheck (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(rc_start),
    .axis(hdr_q[`AMDM_F_AXIS +: 2]),
    .lo(lim_q[15:0]),
    .hi(lim_q[31:16]),
    .ent_valid(set_valid_q[rc_idx]),
    .ent_axis(set_axis_q[rc_idx*2 +: 2]),
    .ent_lo(set_lo_q[rc_idx*16 +: 16]),
    .ent_hi(set_hi_q[rc_idx*16 +: 16]),
    .idx(rc_idx),
    .kill(rc_kill),
    .done(rc_done)
  );

  // read port answers, one cycle after the strobe
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 32'h00000000;
      pgm_rdata_q <= 32'h00000000;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux(reg_addr) : 32'h00000000;
      pgm_rdata_q <= pgm_rd ? rd_mux(pgm_addr) : 32'h00000000;
    end
  end

  // interrupt status: a new event beats the read that clears it
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ist_q <= 5'h00;
      irq_q <= 1'b0;
    end else begin
      ist_q <= ist_d;
      irq_q <= |(ist_d & imask_d);
    end
  end

  // staging, configuration and set table
  always @(posedge core_clk) begin
    if (!rst_n) begin
      hdr_q <= 32'h00000000;
      id_q <= 32'h00000000;
      lock_q <= 32'h00000000;
      lim_q <= 32'h00000000;
      free_q <= 32'h00000000;
      imask_q <= 5'h00;
      modnum_q <= `AMDM_MODNUM_RST;
      rb_sel_q <= 2'h0;
      setpos_q <= 32'h00000000;
      set_valid_q <= 8'h00;
      set_axis_q <= 16'h0000;
      set_lo_q <= 128'h0;
      set_hi_q <= 128'h0;
    end else begin
      if (wr) begin
        case (waddr)
          `AMDM_A_IMASK: imask_q <= wdata[4:0];
          `AMDM_A_RBSEL: rb_sel_q <= wdata[1:0];
          default: begin
          end
        endcase
      end
      // the staged set is frozen while an entry is being processed
      if (stage_wr) begin
        case (waddr)
          `AMDM_A_HDR: hdr_q <= wdata;
          `AMDM_A_ID: id_q <= wdata;
          `AMDM_A_LOCK: lock_q <= wdata;
          `AMDM_A_LIM: lim_q <= wdata;
          `AMDM_A_FREE: free_q <= wdata;
          `AMDM_A_SETPOS: setpos_q <= wdata;
          `AMDM_A_MODNUM: begin
            // module number only editable while no axis holds data
            if (md_valid_q == 3'h0) begin
              modnum_q <= wdata[7:0];
            end
          end
          `AMDM_A_SETCMD: begin
            set_valid_q[slot] <= wdata[5];
            set_axis_q[slot*2 +: 2] <= slot_ax;
            set_lo_q[slot*16 +: 16] <= setpos_q[15:0];
            set_hi_q[slot*16 +: 16] <= setpos_q[31:16];
          end
          default: begin
          end
        endcase
      end
      if (rc_kill) begin
        set_valid_q[rc_idx] <= 1'b0;
      end
    end
  end

  // entry and delete sequencing
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      err_q <= `AMDM_E_NONE;
      md_valid_q <= 3'h0;
      md_dsn_q <= 24'h000000;
      md_lock_q <= 96'h0;
      md_lim_q <= 96'h0;
      md_free_q <= 96'h0;
      axis_clear_q <= 3'h0;
      axis_ctl_q <= 24'h000000;
    end else begin
      axis_clear_q <= 3'h0;
      if (stage_wr && (waddr == `AMDM_A_AXCTL)) begin
        axis_ctl_q <= wdata[23:0] & {3{`AMDM_CTL_MASK}};
      end
      case (state_q)
        S_IDLE: begin
          // a second enter while busy never reaches here
          if (cmd_enter) begin
            state_q <= S_CHECK;
          end
          if (cmd_del && del_ok) begin
            md_valid_q[del_ai] <= 1'b0;
            // pulse clears set statuses, pending settings, errors, offsets
            axis_clear_q[del_ai] <= 1'b1;
            axis_ctl_q[del_ai*8 +: 8] <= 8'h00;
            // cam and target slots stay; the recheck of the next entry on that axis judges them
          end
        end
        S_CHECK: begin
          // error word only changes here, so it holds until the next entry
          err_q <= chk_err;
          if (chk_err != `AMDM_E_NONE) begin
            state_q <= S_IDLE;
          end else begin
            md_valid_q[ent_ai] <= 1'b1;
            md_dsn_q[ent_ai*8 +: 8] <= hdr_q[7:0];
            md_lock_q[ent_ai*32 +: 32] <= lock_q;
            md_lim_q[ent_ai*32 +: 32] <= lim_q;
            md_free_q[ent_ai*32 +: 32] <= free_q;
            state_q <= S_RECHK;
          end
        end
        S_RECHK: begin
          if (rc_done) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== dv/amdm_assertions.sv
`timescale 1ns/10ps

module amdm_assertions (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // read ports
  input wire reg_rd,
  input wire [31:0] reg_rdata_q,
  input wire pgm_rd,
  input wire [31:0] pgm_rdata_q,
  // axis state
  input wire [2:0] axis_done,
  input wire [2:0] md_valid_q,
  input wire [2:0] axis_clear_q,
  input wire [23:0] axis_ctl_q,
  input wire irq_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_rd_idle;
    !reg_rd |=> reg_rdata_q == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("controller rdata not idle");
  property p_pgm_idle;
    !pgm_rd |=> pgm_rdata_q == 32'h0;
  endproperty
  a_pgm_idle: assert property (p_pgm_idle) else $error("programmer rdata not idle");
  // a delete may only land on an axis that was completed when it was taken
  property p_clr_done;
    (axis_clear_q & ~$past(axis_done)) == 3'h0;
  endproperty
  a_clr_done: assert property (p_clr_done) else $error("delete on busy axis");
  property p_clr_ax1;
    axis_clear_q[0] |-> axis_ctl_q[7:0] == 8'h00 && !md_valid_q[0];
  endproperty
  a_clr_ax1: assert property (p_clr_ax1) else $error("axis 1 not cleared");
  property p_clr_ax2;
    axis_clear_q[1] |-> axis_ctl_q[15:8] == 8'h00 && !md_valid_q[1];
  endproperty
  a_clr_ax2: assert property (p_clr_ax2) else $error("axis 2 not cleared");
  property p_clr_ax3;
    axis_clear_q[2] |-> axis_ctl_q[23:16] == 8'h00 && !md_valid_q[2];
  endproperty
  a_clr_ax3: assert property (p_clr_ax3) else $error("axis 3 not cleared");
  // a rejected entry must never take the old set away
  property p_valid_drop;
    (($past(md_valid_q) & ~md_valid_q) & ~axis_clear_q) == 3'h0;
  endproperty
  a_valid_drop: assert property (p_valid_drop) else $error("set lost without delete");
  property p_valid_rise;
    ((md_valid_q & ~$past(md_valid_q)) & ~$past(axis_done)) == 3'h0;
  endproperty
  a_valid_rise: assert property (p_valid_rise) else $error("set stored on busy axis");

  c_delete: cover property (axis_clear_q != 3'h0);
  c_irq: cover property ($rose(irq_q));
  c_enter: cover property ($rose(md_valid_q[1]));
endmodule

// ===== dv/amdm_host.sv
`timescale 1ns/10ps
`include "amdm_defs.vh"

module amdm_host (
  // clock
  input wire core_clk,
  // register port
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire [31:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // stage a set, start the entry, then hold off until the interface is free
  task automatic enter(input logic [31:0] h, lk, lm, output logic [31:0] e);
    logic [31:0] s;
    put(`AMDM_A_HDR, h);
    put(`AMDM_A_ID, `AMDM_MODULE_ID);
    put(`AMDM_A_LOCK, lk);
    put(`AMDM_A_LIM, lm);
    put(`AMDM_A_CMD, 32'h1);
    s = 32'h20;
    for (int i = 0; i < 20 && s[5]; i++) get(`AMDM_A_STAT, s);
    get(`AMDM_A_ERR, e);
    // an interface that never frees returns an impossible error word
    if (s[5]) e = 32'hFFFF_FFFF;
  endtask
endmodule

// ===== dv/amdm_top_tb.sv
`timescale 1ns/10ps
`include "amdm_defs.vh"

module amdm_top_tb;
  localparam logic [31:0] LK = 32'h10;
  localparam logic [31:0] LM = 32'h0100_0000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] axis_done = 3'h7;
  wire [7:0] reg_addr, pgm_addr;
  wire [31:0] reg_wdata, pgm_wdata, reg_rdata_q, pgm_rdata_q;
  wire reg_wr, reg_rd, pgm_wr, pgm_rd, irq_q;
  wire [2:0] md_valid_q, axis_clear_q;
  wire [23:0] axis_ctl_q;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] v;

  always #12.5 core_clk = ~core_clk;

  amdm_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .pgm_addr(pgm_addr), .pgm_wdata(pgm_wdata), .pgm_wr(pgm_wr), .pgm_rd(pgm_rd),
    .pgm_rdata_q(pgm_rdata_q), .axis_done(axis_done), .md_valid_q(md_valid_q),
    .axis_clear_q(axis_clear_q), .axis_ctl_q(axis_ctl_q), .irq_q(irq_q));
  amdm_host ctl (.core_clk(core_clk), .addr(reg_addr), .wdata(reg_wdata), .wr(reg_wr),
    .rd(reg_rd), .rdata(reg_rdata_q));
  amdm_host pgm (.core_clk(core_clk), .addr(pgm_addr), .wdata(pgm_wdata), .wr(pgm_wr),
    .rd(pgm_rd), .rdata(pgm_rdata_q));

  function automatic logic [31:0] hdr(input logic [1:0] ax, input logic [7:0] dsn);
    return {14'h0, ax, 8'h01, dsn};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic t_reset;
    pgm.get(`AMDM_A_MODNUM, v);
    chk("modnum", 32'h1, v);
    pgm.get(`AMDM_A_ERR, v);
    chk("err", 32'h0, v);
    ctl.get(8'hFC, v);
    chk("unmapped", 32'h0, v);
    chk("valid", 32'h0, md_valid_q);
  endtask
  task automatic t_enter;
    ctl.enter(hdr(2'd1, 8'h05), LK, LM, v);
    chk("err", 32'h0, v);
    chk("valid", 32'h1, md_valid_q);
    @(posedge core_clk) axis_done <= 3'h0;
    pgm.put(`AMDM_A_RBSEL, 32'h1);
    pgm.get(`AMDM_A_RBHDR, v);
    chk("rbhdr", hdr(2'd1, 8'h05), v);
    @(posedge core_clk) axis_done <= 3'h7;
  endtask
  // every refusal in priority order; the stored set must survive each one
  task automatic t_errors;
    logic [31:0] h[8] = '{32'h0001_0205, hdr(2'd0, 8'h09), hdr(2'd3, 8'h09),
      hdr(2'd1, 8'h06), hdr(2'd2, 8'h05), hdr(2'd1, 8'h05), hdr(2'd2, 8'h09),
      hdr(2'd2, 8'h09)};
    logic [31:0] k[8] = '{LK, LK, LK, LK, LK, 32'h11, 32'h0, 32'h0200_0010};
    @(posedge core_clk) axis_done <= 3'h3;
    for (int i = 0; i < 8; i++) begin
      ctl.enter(h[i], k[i], LM, v);
      chk("errnum", i + 1, v);
      chk("valid", 32'h1, md_valid_q);
    end
    @(posedge core_clk) axis_done <= 3'h7;
    pgm.get(`AMDM_A_RBLOCK, v);
    chk("rblock", LK, v);
    pgm.get(`AMDM_A_ERR, v);
    chk("errheld", 32'h8, v);
    pgm.put(`AMDM_A_MODNUM, 32'h2);
    pgm.get(`AMDM_A_MODNUM, v);
    chk("modnum", 32'h1, v);
  endtask
  task automatic t_recheck;
    ctl.put(`AMDM_A_SETPOS, 32'h0020_0010);
    ctl.put(`AMDM_A_SETCMD, 32'h30);
    ctl.put(`AMDM_A_SETPOS, 32'h0300_0010);
    ctl.put(`AMDM_A_SETCMD, 32'h31);
    ctl.get(`AMDM_A_SETCMD, v);
    chk("sets", 32'h3, v);
    pgm.enter(hdr(2'd2, 8'h07), LK, LM, v);
    chk("err", 32'h0, v);
    ctl.get(`AMDM_A_SETCMD, v);
    chk("sets", 32'h1, v);
  endtask
  task automatic t_irq;
    chk("irq", 32'h0, irq_q);
    ctl.put(`AMDM_A_IMASK, 32'h1F);
    @(posedge core_clk);
    #1 chk("irq", 32'h1, irq_q);
    ctl.get(`AMDM_A_IST, v);
    chk("ist", 32'h13, v);
    @(posedge core_clk);
    #1 chk("irq", 32'h0, irq_q);
  endtask
  task automatic t_delete;
    ctl.enter(hdr(2'd3, 8'h08), 32'h0100_0010, LM, v);
    chk("err", 32'h0, v);
    ctl.put(`AMDM_A_AXCTL, 32'h7F7F7F);
    ctl.put(`AMDM_A_CMD, 32'h6);
    #1 chk("clear", 32'h0, axis_clear_q);
    @(posedge core_clk) axis_done <= 3'h5;
    ctl.put(`AMDM_A_CMD, 32'hA);
    #1 chk("clear", 32'h0, axis_clear_q);
    @(posedge core_clk) axis_done <= 3'h7;
    chk("valid", 32'h7, md_valid_q);
    ctl.put(`AMDM_A_CMD, 32'hE);
    #1 chk("clear", 32'h4, axis_clear_q);
    chk("valid", 32'h3, md_valid_q);
    chk("ctl", 32'h007F7F, axis_ctl_q);
    ctl.put(`AMDM_A_CMD, 32'h6);
    #1 chk("clear", 32'h1, axis_clear_q);
    chk("ctl", 32'h007F00, axis_ctl_q);
    ctl.get(`AMDM_A_IST, v);
    chk("ist", 32'h0D, v);
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_enter();
    t_errors();
    t_recheck();
    t_irq();
    t_delete();
    end_of_test();
  end
  // the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule

bind amdm_top amdm_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .pgm_rd(pgm_rd), .pgm_rdata_q(pgm_rdata_q),
  .axis_done(axis_done), .md_valid_q(md_valid_q), .axis_clear_q(axis_clear_q),
  .axis_ctl_q(axis_ctl_q), .irq_q(irq_q));
